// [rtl/wdt_pkg.sv]
package wdt_pkg;

  // Clock rate and the base tick that all long periods are counted in.
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_US = 50;
  localparam int unsigned TICK_CYCLES_DEF = TICK_US * CLK_MHZ;

  // Normal timeouts in microseconds.
  localparam int unsigned WD_TO0_US = 1000;
  localparam int unsigned WD_TO1_US = 4000;
  localparam int unsigned WD_TO2_US = 12500;
  localparam int unsigned WD_TO3_US = 50000;
  localparam int unsigned WD_TO4_US = 200000;
  localparam int unsigned WD_TO5_US = 800000;
  localparam int unsigned WD_TO6_US = 1600000;
  localparam int unsigned WD_TO7_US = 3200000;

  // Long startup delays in microseconds.
  localparam int unsigned WD_SU0_US = 25600000;
  localparam int unsigned WD_SU1_US = 51200000;
  localparam int unsigned WD_SU2_US = 102400000;
  localparam int unsigned WD_SU3_US = 128000000;

  // Periods expressed in ticks.
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] WD_TO0_TICKS = CNT_W'(WD_TO0_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_TO1_TICKS = CNT_W'(WD_TO1_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_TO2_TICKS = CNT_W'(WD_TO2_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_TO3_TICKS = CNT_W'(WD_TO3_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_TO4_TICKS = CNT_W'(WD_TO4_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_TO5_TICKS = CNT_W'(WD_TO5_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_TO6_TICKS = CNT_W'(WD_TO6_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_TO7_TICKS = CNT_W'(WD_TO7_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_SU0_TICKS = CNT_W'(WD_SU0_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_SU1_TICKS = CNT_W'(WD_SU1_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_SU2_TICKS = CNT_W'(WD_SU2_US / TICK_US);
  localparam logic [CNT_W-1:0] WD_SU3_TICKS = CNT_W'(WD_SU3_US / TICK_US);

  // Alarm pulse length in system clock cycles when expiry drives reset.
  localparam logic [1:0] ALARM_PULSE_CYCLES = 2'h3;

  // Register offsets.
  localparam logic [7:0] MODE_OFFSET = 8'h4d;
  localparam logic [7:0] CFG_OFFSET = 8'h55;
  localparam logic [7:0] STATUS_OFFSET = 8'h56;

  // Reset values.
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Mode register fields.
  localparam int MODE_SEQ_DIS_BIT = 0;
  localparam int MODE_MARGIN_BIT = 1;
  localparam int MODE_EW_OV_BIT = 2;
  localparam int MODE_INDEP_BIT = 3;

  // Configuration register fields.
  localparam int CFG_TO_LSB = 0;
  localparam int CFG_SU_LSB = 3;
  localparam int CFG_EN_BIT = 5;
  localparam int CFG_SU_EN_BIT = 6;
  localparam int CFG_RST_EN_BIT = 7;

  // Watchdog states.
  typedef enum logic [2:0] {
    WD_OFF,
    WD_STARTUP,
    WD_RUN,
    WD_ALARM,
    WD_PULSE
  } wd_state_t;

endpackage

// [rtl/edge_sync_if.sv]
// Filtered level and edge strobe of a synchronised pin.
interface edge_sync_if;
  logic level;
  logic edge_seen;
  modport src (output level, output edge_seen);
  modport dst (input level, input edge_seen);
endinterface

// [rtl/pin_sync.sv]
module pin_sync
  import wdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic pin,
  edge_sync_if.src sync
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;
  logic edge_reg;
  logic edge_next;

  // Stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree.
  always_comb begin
    stage_next = {stage_reg[1:0], pin};
    level_next = level_reg;
    edge_next = 1'b0;
    if (stage_reg[1] == stage_reg[2] && stage_reg[2] != level_reg) begin
      level_next = stage_reg[2];
      edge_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
      edge_reg <= edge_next;
    end
  end

  assign sync.level = level_reg;
  assign sync.edge_seen = edge_reg;

endmodule

// [rtl/supervisory_watchdog_timer.sv]
module supervisory_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic kick_input,
  input wire logic seq_gate_input,
  input wire logic supply_ok,
  input wire logic boot_done,
  input wire logic seq_done,
  input wire logic seq_reset_active,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic watchdog_alarm_out_n,
  output logic wd_reset_req,
  output logic seq_start,
  output logic margin_enable,
  output logic early_warn_overvoltage
);

  // Last prescaler count of one coarse tick; the prescaler wraps to zero after it.
  localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

  // Reset release synchroniser; assertion stays asynchronous.
  // Release is retimed so that no flip-flop leaves reset on a different edge
  // from its neighbours, which could otherwise start the watchdog half reset.
  logic [1:0] rst_pipe_reg;
  logic [1:0] rst_pipe_next;
  logic rst_sync_n;

  // A one is shifted in behind the released external reset.
  always_comb begin
    rst_pipe_next = {rst_pipe_reg[0], 1'b1};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= rst_pipe_next;
    end
  end

  assign rst_sync_n = rst_pipe_reg[1];

  // Pin synchronisers for the kick and the sequence gate.
  edge_sync_if kick_sync ();
  edge_sync_if gate_sync ();

  pin_sync u_kick_sync (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .pin(kick_input),
    .sync(kick_sync.src)
  );

  pin_sync u_gate_sync (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .pin(seq_gate_input),
    .sync(gate_sync.src)
  );

  // Register file state.
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Watchdog state.
  wd_state_t state_reg;
  wd_state_t state_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [13:0] presc_reg;
  logic [13:0] presc_next;
  logic [1:0] pulse_reg;
  logic [1:0] pulse_next;
  logic alarm_reg;
  logic alarm_next;
  logic rst_req_reg;
  logic rst_req_next;
  logic seq_start_reg;
  logic seq_start_next;
  logic alarm_n_reg;
  logic alarm_n_next;

  // Decoded controls shared by the watchdog processes.
  logic indep;
  logic active;
  logic tick;
  logic [CNT_W-1:0] to_ticks;
  logic [CNT_W-1:0] su_ticks;
  logic [CNT_W-1:0] limit;

  // Period selection from the configuration fields.
  always_comb begin
    case (cfg_reg[CFG_TO_LSB +: 3])
      3'h0: to_ticks = WD_TO0_TICKS;
      3'h1: to_ticks = WD_TO1_TICKS;
      3'h2: to_ticks = WD_TO2_TICKS;
      3'h3: to_ticks = WD_TO3_TICKS;
      3'h4: to_ticks = WD_TO4_TICKS;
      3'h5: to_ticks = WD_TO5_TICKS;
      3'h6: to_ticks = WD_TO6_TICKS;
      default: to_ticks = WD_TO7_TICKS;
    endcase
    case (cfg_reg[CFG_SU_LSB +: 2])
      2'h0: su_ticks = WD_SU0_TICKS;
      2'h1: su_ticks = WD_SU1_TICKS;
      2'h2: su_ticks = WD_SU2_TICKS;
      default: su_ticks = WD_SU3_TICKS;
    endcase
    // A startup window runs on the long limit; every other state uses the
    // normal timeout.
    limit = (state_reg == WD_STARTUP) ? su_ticks : to_ticks;
  end

  // Activation gate: independent mode follows supply and boot only, while
  // dependent mode needs finished sequencing and a released supervisor reset.
  // Enable low holds the watchdog in reset whatever the mode.
  assign indep = mode_reg[MODE_INDEP_BIT];
  always_comb begin
    if (!cfg_reg[CFG_EN_BIT]) begin
      active = 1'b0;
    end else if (indep) begin
      active = supply_ok && boot_done;
    end else begin
      active = seq_done && !seq_reset_active;
    end
  end

  // One coarse tick every TICK_CYCLES clocks; the timeout and startup periods count these.
  assign tick = (presc_reg == TICK_LAST);

  // Register writes and reads; the status word shows the watchdog itself.
  always_comb begin
    mode_next = mode_reg;
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    if (reg_we && reg_addr == MODE_OFFSET) begin
      // Unused mode bits are dropped so that they always read back as zero.
      mode_next = {4'h0, reg_wdata[3:0]};
    end
    if (reg_we && reg_addr == CFG_OFFSET) begin
      cfg_next = reg_wdata;
    end
    if (reg_re) begin
      // Read data is registered and holds until the next read strobe.
      case (reg_addr)
        MODE_OFFSET: rdata_next = mode_reg;
        CFG_OFFSET: rdata_next = cfg_reg;
        STATUS_OFFSET: rdata_next = {3'h0, state_reg, rst_req_reg, alarm_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_reg <= MODE_RESET;
      cfg_reg <= CFG_RESET;
      rdata_reg <= 8'h00;
    end else begin
      mode_reg <= mode_next;
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // Watchdog sequencing. Periods are counted in coarse ticks so a 128 s
  // delay fits a narrow counter; the prescaler is zeroed on every restart, so no tick of jitter results.
  // Kick edges arrive three to four clocks after the pin moves, which is
  // small against the shortest timeout.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    presc_next = tick ? 14'h0 : presc_reg + 14'h1;
    pulse_next = pulse_reg;
    alarm_next = alarm_reg;
    rst_req_next = 1'b0;
    if (!active) begin
      // Losing activation disarms at once and releases the alarm; the
      // count restarts from zero when activation returns.
      state_next = WD_OFF;
      alarm_next = 1'b0;
      count_next = '0;
      presc_next = 14'h0;
    end else begin
      case (state_reg)
        WD_OFF: begin
          // Arming: the long startup window only when it is enabled.
          state_next = cfg_reg[CFG_SU_EN_BIT] ? WD_STARTUP : WD_RUN;
          count_next = '0;
          presc_next = 14'h0;
        end
        WD_STARTUP, WD_RUN: begin
          // A kick in the same cycle as expiry wins, so a processor that
          // kicks at the last moment is never punished for the race.
          if (kick_sync.edge_seen) begin
            state_next = WD_RUN;
            count_next = '0;
            presc_next = 14'h0;
          // Expiry falls on the last tick of the selected period.
          end else if (tick && count_reg == limit - CNT_W'(1)) begin
            alarm_next = 1'b1;
            count_next = '0;
            if (cfg_reg[CFG_RST_EN_BIT]) begin
              state_next = WD_PULSE;
              pulse_next = 2'h1;
            end else begin
              state_next = WD_ALARM;
            end
          end else if (tick) begin
            count_next = count_reg + CNT_W'(1);
          end
        end
        WD_ALARM: begin
          // The alarm stands until the processor shows life again or activation is lost.
          if (kick_sync.edge_seen) begin
            alarm_next = 1'b0;
            state_next = WD_RUN;
            count_next = '0;
            presc_next = 14'h0;
          end
        end
        WD_PULSE: begin
          // Alarm first, then the reset request, then the alarm release.
          if (pulse_reg == 2'h1) begin
            rst_req_next = 1'b1;
          end
          // The pulse counter starts at one on entry, so three cycles pass here.
          if (pulse_reg == ALARM_PULSE_CYCLES) begin
            alarm_next = 1'b0;
            state_next = WD_OFF;
            pulse_next = 2'h0;
          end else begin
            pulse_next = pulse_reg + 2'h1;
          end
        end
        default: begin
          // An illegal state code falls back to a safe, disarmed state.
          state_next = WD_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= WD_OFF;
      count_reg <= '0;
      presc_reg <= 14'h0;
      pulse_reg <= 2'h0;
      alarm_reg <= 1'b0;
      rst_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      presc_reg <= presc_next;
      pulse_reg <= pulse_next;
      alarm_reg <= alarm_next;
      rst_req_reg <= rst_req_next;
    end
  end

  // Sequencing start needs both the software enable and the gate pin.
  // The gate is a pin, so its filtered level is used, never the raw input.
  always_comb begin
    seq_start_next = !mode_reg[MODE_SEQ_DIS_BIT] && gate_sync.level;
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq_start_reg <= 1'b0;
    end else begin
      seq_start_reg <= seq_start_next;
    end
  end

  // The pin copy of the alarm is active low. It is registered from the same
  // next value as the internal alarm so that the pin carries no inverter
  // after the flip-flop and both copies always move on the same edge.
  always_comb begin
    alarm_n_next = !alarm_next;
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alarm_n_reg <= 1'b1;
    end else begin
      alarm_n_reg <= alarm_n_next;
    end
  end

  // Outputs all come from flip-flops, so no logic glitch can reach a pin.
  assign reg_rdata = rdata_reg;
  assign watchdog_alarm_out_n = alarm_n_reg;
  assign wd_reset_req = rst_req_reg;
  assign seq_start = seq_start_reg;
  assign margin_enable = mode_reg[MODE_MARGIN_BIT];
  assign early_warn_overvoltage = mode_reg[MODE_EW_OV_BIT];

endmodule

// [verification/kick_host.sv]
module kick_host #(
  parameter int PERIOD = 40
) (
  input wire logic mclk,
  input wire logic run,
  input wire logic kick_now,
  output logic kick_input
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial kick_input = 1'b0;
  // The processor flips the pin just after a rising edge, away from the bench's
  // falling-edge strobes, so each strobe gives exactly one kick of either direction.
  always @(posedge mclk) begin
    cnt = (run && cnt < PERIOD) ? cnt + 1 : 0;
    if (kick_now || (run && cnt == PERIOD)) kick_input <= ~kick_input;
  end
endmodule

// [verification/supervisory_watchdog_timer_chk.sv]
module supervisory_watchdog_timer_chk
  import wdt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic kick_input,
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic watchdog_alarm_out_n,
  input wire logic wd_reset_req,
  input wire logic margin_enable,
  input wire logic early_warn_overvoltage
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MIN_TO = 20 * TICK_CYCLES;
  logic kick_reg, kick_next;
  logic [31:0] quiet_reg, quiet_next;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Cycles since the pin last moved; saturates so a long idle cannot wrap to zero.
  always_comb begin
    kick_next = kick_input;
    quiet_next = (kick_input != kick_reg) ? 32'h0 : quiet_reg + {31'h0, quiet_reg != 32'hffffffff};
  end
  // Registers the quiet counter.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      kick_reg <= 1'b0;
      quiet_reg <= 32'h0;
    end else begin
      kick_reg <= kick_next;
      quiet_reg <= quiet_next;
    end
  end
  a_req_inside_alarm: assert property (wd_reset_req |-> !watchdog_alarm_out_n &&
    !$past(watchdog_alarm_out_n)) else $error("reset request outside alarm pulse");
  a_req_one_cycle: assert property (wd_reset_req |=> !wd_reset_req)
    else $error("reset request longer than one cycle");
  a_alarm_then_release: assert property ($fell(wd_reset_req) |=> watchdog_alarm_out_n)
    else $error("alarm not released after reset request");
  a_pulse_three_cycles: assert property ($fell(watchdog_alarm_out_n) ##1 wd_reset_req
    |=> !watchdog_alarm_out_n ##1 watchdog_alarm_out_n) else $error("alarm pulse not three cycles");
  a_kick_clears_alarm: assert property ($changed(kick_input) && !watchdog_alarm_out_n
    |-> ##[1:8] watchdog_alarm_out_n) else $error("kick did not release alarm");
  a_expiry_not_early: assert property ($fell(watchdog_alarm_out_n) |-> quiet_reg >= MIN_TO)
    else $error("alarm before shortest timeout");
  a_mode_out_cause: assert property ($changed(margin_enable) ||
    $changed(early_warn_overvoltage) |-> ($past(reg_we) && $past(reg_addr) == MODE_OFFSET) ||
    ($past(reg_we, 2) && $past(reg_addr, 2) == MODE_OFFSET)) else $error("mode output moved");
  a_mode_read_back: assert property (reg_re && !reg_we && reg_addr == MODE_OFFSET |=>
    reg_rdata[7:4] == 4'h0 && reg_rdata[2:1] == {early_warn_overvoltage, margin_enable})
    else $error("mode read disagrees with outputs");
  a_unmapped_zero: assert property (reg_re && reg_addr != MODE_OFFSET &&
    reg_addr != CFG_OFFSET && reg_addr != STATUS_OFFSET |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_reset_req: cover property ($rose(wd_reset_req));
  c_alarm: cover property ($fell(watchdog_alarm_out_n));
  c_mode_read: cover property (reg_re && reg_addr == MODE_OFFSET);
endmodule

bind supervisory_watchdog_timer supervisory_watchdog_timer_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .kick_input(kick_input), .reg_addr(reg_addr), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .watchdog_alarm_out_n(watchdog_alarm_out_n),
  .wd_reset_req(wd_reset_req), .margin_enable(margin_enable),
  .early_warn_overvoltage(early_warn_overvoltage));

// [verification/supervisory_watchdog_timer_tb_top.sv]
module supervisory_watchdog_timer_tb_top;
  import wdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TK = 4;
  logic mclk = 1'b0, rst_n = 1'b0, gate = 1'b0, supply_ok = 1'b0, boot_done = 1'b0;
  logic seq_done = 1'b0, seq_rst = 1'b0, we = 1'b0, re = 1'b0, run = 1'b0, kick_now = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic kick, alarm_n, rst_req, seq_start, margin, ew_ov;
  int n_mismatch = 0, n_compared = 0, n_req = 0, i;
  int lim[3] = '{WD_TO0_US / TICK_US, WD_TO1_US / TICK_US, WD_TO2_US / TICK_US};
  // Free-running 250 MHz clock.
  always #2 mclk = ~mclk;
  // Counts reset requests so that silent expiries can be told apart.
  always @(posedge mclk) if (rst_req === 1'b1) n_req++;
  supervisory_watchdog_timer #(.TICK_CYCLES(TK)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .kick_input(kick), .seq_gate_input(gate), .supply_ok(supply_ok), .boot_done(boot_done),
    .seq_done(seq_done), .seq_reset_active(seq_rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_we(we), .reg_re(re), .reg_rdata(rdata), .watchdog_alarm_out_n(alarm_n),
    .wd_reset_req(rst_req), .seq_start(seq_start), .margin_enable(margin),
    .early_warn_overvoltage(ew_ov));
  kick_host #(.PERIOD(40)) host_u (.mclk(mclk), .run(run), .kick_now(kick_now), .kick_input(kick));
  task automatic tick(input int n); repeat (n) @(negedge mclk); endtask
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a; wdata = d; we = 1'b1; tick(1); we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a; re = 1'b1; tick(1); re = 1'b0; tick(1); ck(rdata, exp);
  endtask
  task automatic kick1; kick_now = 1'b1; tick(1); kick_now = 1'b0; endtask
  // Bounded wait for a level, then compare it; a miss shows as a mismatch.
  task automatic waitfor(ref logic s, input logic lvl, input int lim_c);
    for (int w = 0; w < lim_c && s !== lvl; w++) tick(1);
    ck({7'h0, s}, {7'h0, lvl});
  endtask
  task test_done;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard: the sequence needs about 3000 cycles, so 60 us is ample.
  initial begin
    #60us;
    n_mismatch++;
    test_done();
  end
  initial begin
    tick(6); rst_n = 1'b1; tick(4);
    rd(MODE_OFFSET, MODE_RESET);
    rd(CFG_OFFSET, CFG_RESET);
    rd(8'h60, 8'h00);
    wr(MODE_OFFSET, 8'hff); rd(MODE_OFFSET, 8'h0f);
    ck({6'h0, ew_ov, margin}, 8'h03);
    gate = 1'b1; wr(MODE_OFFSET, 8'h0e); tick(8); ck({7'h0, seq_start}, 8'h01);
    gate = 1'b0; tick(8); ck({7'h0, seq_start}, 8'h00);
    wr(MODE_OFFSET, 8'h08); tick(2); ck({6'h0, ew_ov, margin}, 8'h00);
    supply_ok = 1'b1; boot_done = 1'b1; tick(150); ck({7'h0, alarm_n}, 8'h01);
    boot_done = 1'b0; wr(CFG_OFFSET, 8'h20); tick(150); ck({7'h0, alarm_n}, 8'h01);
    boot_done = 1'b1;
    // Timeout codes 0 to 2: still quiet just before the limit, alarm shortly after.
    for (i = 0; i < 3; i++) begin
      wr(CFG_OFFSET, 8'h20 | 8'(i)); kick1();
      tick(lim[i] * TK - 10); ck({7'h0, alarm_n}, 8'h01);
      waitfor(alarm_n, 1'b0, 40);
    end
    wr(CFG_OFFSET, 8'h20); run = 1'b1; tick(300); ck({7'h0, alarm_n}, 8'h01);
    run = 1'b0; waitfor(alarm_n, 1'b0, 200);
    seq_rst = 1'b1; tick(20); ck({7'h0, alarm_n}, 8'h00);
    rd(STATUS_OFFSET, 8'h0d);
    seq_rst = 1'b0; kick1(); waitfor(alarm_n, 1'b1, 8);
    wr(CFG_OFFSET, 8'ha0); kick1(); waitfor(rst_req, 1'b1, 200);
    ck({7'h0, alarm_n}, 8'h00); tick(1); ck({7'h0, alarm_n}, 8'h00);
    tick(1); ck({7'h0, alarm_n}, 8'h01);
    wr(CFG_OFFSET, 8'h20); kick1(); waitfor(alarm_n, 1'b0, 120);
    tick(20); ck(8'(n_req), 8'h01);
    wr(MODE_OFFSET, 8'h01); tick(150); ck({7'h0, alarm_n}, 8'h01);
    seq_done = 1'b1; waitfor(alarm_n, 1'b0, 150);
    seq_rst = 1'b1; waitfor(alarm_n, 1'b1, 4);
    tick(150); ck({7'h0, alarm_n}, 8'h01);
    wr(CFG_OFFSET, 8'h60); seq_rst = 1'b0; tick(150); ck({7'h0, alarm_n}, 8'h01);
    kick1(); waitfor(alarm_n, 1'b0, 120);
    test_done();
  end
endmodule
